// >>> hdl/dual_timer_counter.sv
// dual 16-bit timer/counter with external interrupt flags and control registers
// assumes: processor core reaches registers by 8-bit address with read/write strobes;
// pins and interrupt inputs are asynchronous to clk
`timescale 1ns/1ps
module dual_timer_counter
   import dual_timer_counter_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic timer0_pin,
   input wire logic timer1_pin,
   input wire logic ext_irq0_input,
   input wire logic ext_irq1_input,
   input wire logic ext_irq0_ack,
   input wire logic ext_irq1_ack,
   input wire logic timer0_ack,
   input wire logic timer1_ack,
   output logic ext_irq0_req,
   output logic ext_irq1_req,
   output logic timer0_overflow_flag,
   output logic timer1_overflow_flag
);
   import dual_timer_counter_pkg::*;

   logic [7:0] timer_control_flags_q;
   logic [7:0] timer_mode_select_q;
   logic [3:0] phase_q;
   logic mc_tick;
   logic [3:0] pin_sync1_q;
   logic [3:0] pin_sync2_q;
   logic [3:0] pin_prev_q;
   logic [3:0] pin_fall_q;
   logic t0_inc;
   logic t1_inc;
   logic t0_hi_inc;
   logic t0_low_ovf;
   logic t0_high_ovf;
   logic t1_low_ovf;
   logic [7:0] t0_low;
   logic [7:0] t0_high;
   logic [7:0] t1_low;
   logic [7:0] t1_high;
   logic wr_ctl;
   logic wr_mode;

   ////////////////////////////////////////////////////////////////////////////
   // machine cycle divider
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         phase_q <= 4'h0;
      else if (phase_q == PHASE_LAST)
         phase_q <= 4'h0;
      else
         phase_q <= phase_q + 4'h1;
   end
   assign mc_tick = (phase_q == PHASE_LAST);

   ////////////////////////////////////////////////////////////////////////////
   // synchronise pins: [0]=t0 pin, [1]=t1 pin, [2]=irq0, [3]=irq1
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pin_sync1_q <= 4'hF;
         pin_sync2_q <= 4'hF;
      end
      else
      begin
         pin_sync1_q <= {ext_irq1_input, ext_irq0_input, timer1_pin, timer0_pin};
         pin_sync2_q <= pin_sync1_q;
      end
   end

   // sample once per machine cycle; a fall is seen one machine cycle later,
   // so a 1-to-0 event costs two machine cycles and caps the count rate
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pin_prev_q <= 4'hF;
         pin_fall_q <= 4'h0;
      end
      else if (mc_tick)
      begin
         pin_prev_q <= pin_sync2_q;
         pin_fall_q <= pin_prev_q & ~pin_sync2_q;
      end
      else
         pin_fall_q <= 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // count enables; gate bit combined with counter select picks pin events
   // tick passed as an argument so the assigns re-evaluate on every tick
   function automatic logic count_pulse(input logic run, input logic gate, input logic ct,
                                        input logic fall, input logic tick);
      if (!run)
         count_pulse = 1'b0;
      else if (gate || ct)
         count_pulse = fall;
      else
         count_pulse = tick;
   endfunction : count_pulse

   assign t0_inc = count_pulse(timer_control_flags_q[T0_RUN_BIT],
                               timer_mode_select_q[GATE0_BIT],
                               timer_mode_select_q[CT0_BIT], pin_fall_q[0], mc_tick);
   assign t1_inc = count_pulse(timer_control_flags_q[T1_RUN_BIT],
                               timer_mode_select_q[GATE1_BIT],
                               timer_mode_select_q[CT1_BIT], pin_fall_q[1], mc_tick);
   // split high byte times machine cycles under timer 1 run only
   assign t0_hi_inc = timer_control_flags_q[T1_RUN_BIT] && mc_tick;

   ////////////////////////////////////////////////////////////////////////////
   // counters; timer 1 mode 3 holds (firmware keeps to legal pairs)
   timer_count_unit u_timer0 (
      .clk(clk),
      .sys_rst(sys_rst),
      .mode(timer_mode_select_q[MODE0_LSB +: 2]),
      .is_timer0(1'b1),
      .low_inc(t0_inc),
      .high_inc(t0_hi_inc),
      .wr_low(sfr_wr && sfr_addr == TIMER0_LOW_BYTE_ADDR),
      .wr_high(sfr_wr && sfr_addr == TIMER0_HIGH_BYTE_ADDR),
      .wr_data(sfr_wdata),
      .low_byte_q(t0_low),
      .high_byte_q(t0_high),
      .low_ovf(t0_low_ovf),
      .high_ovf(t0_high_ovf)
   );

   timer_count_unit u_timer1 (
      .clk(clk),
      .sys_rst(sys_rst),
      .mode(timer_mode_select_q[MODE1_LSB +: 2]),
      .is_timer0(1'b0),
      .low_inc(t1_inc),
      .high_inc(1'b0),
      .wr_low(sfr_wr && sfr_addr == TIMER1_LOW_BYTE_ADDR),
      .wr_high(sfr_wr && sfr_addr == TIMER1_HIGH_BYTE_ADDR),
      .wr_data(sfr_wdata),
      .low_byte_q(t1_low),
      .high_byte_q(t1_high),
      .low_ovf(t1_low_ovf),
      .high_ovf()
   );

   ////////////////////////////////////////////////////////////////////////////
   // mode register; no watchdog bits live here
   assign wr_mode = sfr_wr && sfr_addr == TIMER_MODE_SELECT_ADDR;
   assign wr_ctl = sfr_wr && sfr_addr == TIMER_CONTROL_FLAGS_ADDR;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         timer_mode_select_q <= REG_RESET;
      else if (wr_mode)
         timer_mode_select_q <= sfr_wdata;
   end

   ////////////////////////////////////////////////////////////////////////////
   // control/flag register: hardware set beats software or acknowledge clear
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         timer_control_flags_q <= REG_RESET;
      else
      begin
         if (wr_ctl)
            timer_control_flags_q <= sfr_wdata;
         else
         begin
            if (timer1_ack)
               timer_control_flags_q[T1_OVF_BIT] <= 1'b0;
            if (timer0_ack)
               timer_control_flags_q[T0_OVF_BIT] <= 1'b0;
            if (ext_irq1_ack)
               timer_control_flags_q[IRQ1_FLAG_BIT] <= 1'b0;
            if (ext_irq0_ack)
               timer_control_flags_q[IRQ0_FLAG_BIT] <= 1'b0;
         end
         if (t1_low_ovf || t0_high_ovf)
            timer_control_flags_q[T1_OVF_BIT] <= 1'b1;
         if (t0_low_ovf)
            timer_control_flags_q[T0_OVF_BIT] <= 1'b1;
         // edge flags record falls only in edge mode
         if (pin_fall_q[3] && timer_control_flags_q[IRQ1_TYPE_BIT])
            timer_control_flags_q[IRQ1_FLAG_BIT] <= 1'b1;
         if (pin_fall_q[2] && timer_control_flags_q[IRQ0_TYPE_BIT])
            timer_control_flags_q[IRQ0_FLAG_BIT] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // requests and flags out, all registered
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ext_irq0_req <= 1'b0;
         ext_irq1_req <= 1'b0;
         timer0_overflow_flag <= 1'b0;
         timer1_overflow_flag <= 1'b0;
      end
      else
      begin
         // type 1: edge flag; type 0: low level on synchronised input
         ext_irq0_req <= timer_control_flags_q[IRQ0_TYPE_BIT]
                         ? timer_control_flags_q[IRQ0_FLAG_BIT]
                         : ~pin_sync2_q[2];
         ext_irq1_req <= timer_control_flags_q[IRQ1_TYPE_BIT]
                         ? timer_control_flags_q[IRQ1_FLAG_BIT]
                         : ~pin_sync2_q[3];
         timer0_overflow_flag <= timer_control_flags_q[T0_OVF_BIT];
         timer1_overflow_flag <= timer_control_flags_q[T1_OVF_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data registered one cycle after sfr_rd; unmapped reads zero
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         sfr_rdata <= 8'h00;
      else if (sfr_rd)
      begin
         case (sfr_addr)
            TIMER_CONTROL_FLAGS_ADDR: sfr_rdata <= timer_control_flags_q;
            TIMER_MODE_SELECT_ADDR: sfr_rdata <= timer_mode_select_q;
            TIMER0_LOW_BYTE_ADDR: sfr_rdata <= t0_low;
            TIMER1_LOW_BYTE_ADDR: sfr_rdata <= t1_low;
            TIMER0_HIGH_BYTE_ADDR: sfr_rdata <= t0_high;
            TIMER1_HIGH_BYTE_ADDR: sfr_rdata <= t1_high;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end
endmodule : dual_timer_counter

// >>> hdl/dual_timer_counter_pkg.sv
// constants shared by the dual timer/counter block
// assumes: special function register access by 8-bit address, processor clock 20 MHz
package dual_timer_counter_pkg;
   localparam logic [7:0] TIMER_CONTROL_FLAGS_ADDR = 8'h88;
   localparam logic [7:0] TIMER_MODE_SELECT_ADDR = 8'h89;
   localparam logic [7:0] TIMER0_LOW_BYTE_ADDR = 8'h8A;
   localparam logic [7:0] TIMER1_LOW_BYTE_ADDR = 8'h8B;
   localparam logic [7:0] TIMER0_HIGH_BYTE_ADDR = 8'h8C;
   localparam logic [7:0] TIMER1_HIGH_BYTE_ADDR = 8'h8D;
   // control/flag register bit positions
   localparam int T1_OVF_BIT = 7;
   localparam int T1_RUN_BIT = 6;
   localparam int T0_OVF_BIT = 5;
   localparam int T0_RUN_BIT = 4;
   localparam int IRQ1_FLAG_BIT = 3;
   localparam int IRQ1_TYPE_BIT = 2;
   localparam int IRQ0_FLAG_BIT = 1;
   localparam int IRQ0_TYPE_BIT = 0;
   // mode register bit positions
   localparam int GATE1_BIT = 7;
   localparam int CT1_BIT = 6;
   localparam int MODE1_LSB = 4;
   localparam int GATE0_BIT = 3;
   localparam int CT0_BIT = 2;
   localparam int MODE0_LSB = 0;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int CLKS_PER_MACHINE_CYCLE = 12;
   localparam logic [3:0] PHASE_LAST = 4'(CLKS_PER_MACHINE_CYCLE - 1);
   typedef enum logic [1:0]
   {
      MODE_13BIT = 2'h0,
      MODE_16BIT = 2'h1,
      MODE_RELOAD8 = 2'h2,
      MODE_SPLIT = 2'h3
   } mode_t;
endpackage : dual_timer_counter_pkg

// >>> hdl/timer_count_unit.sv
// one timer/counter: low and high count bytes and their mode logic
// assumes: increment enables arrive as one-cycle pulses from the parent
`timescale 1ns/1ps
module timer_count_unit
   import dual_timer_counter_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [1:0] mode,
   input wire logic is_timer0,
   input wire logic low_inc,
   input wire logic high_inc,
   input wire logic wr_low,
   input wire logic wr_high,
   input wire logic [7:0] wr_data,
   output logic [7:0] low_byte_q,
   output logic [7:0] high_byte_q,
   output logic low_ovf,
   output logic high_ovf
);
   logic [8:0] low_sum;
   logic [8:0] high_sum;
   logic [5:0] low5_sum;
   assign low_sum = {1'b0, low_byte_q} + 9'h001;
   assign high_sum = {1'b0, high_byte_q} + 9'h001;
   assign low5_sum = {1'b0, low_byte_q[4:0]} + 6'h01;

   ////////////////////////////////////////////////////////////////////////////
   // overflow pulses per mode
   always_comb
   begin
      low_ovf = 1'b0;
      high_ovf = 1'b0;
      case (mode_t'(mode))
         MODE_13BIT: low_ovf = low_inc && low5_sum[5] && high_sum[8];
         MODE_16BIT: low_ovf = low_inc && low_sum[8] && high_sum[8];
         MODE_RELOAD8: low_ovf = low_inc && low_sum[8];
         MODE_SPLIT:
         begin
            // timer 1 simply holds in this mode
            low_ovf = is_timer0 && low_inc && low_sum[8];
            high_ovf = is_timer0 && high_inc && high_sum[8];
         end
         default: low_ovf = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // low byte; software write wins over a count in the same cycle
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         low_byte_q <= REG_RESET;
      else if (wr_low)
         low_byte_q <= wr_data;
      else if (low_inc)
      begin
         case (mode_t'(mode))
            MODE_13BIT: low_byte_q <= {3'h0, low5_sum[4:0]};
            MODE_16BIT: low_byte_q <= low_sum[7:0];
            MODE_RELOAD8: low_byte_q <= low_sum[8] ? high_byte_q : low_sum[7:0];
            MODE_SPLIT: low_byte_q <= is_timer0 ? low_sum[7:0] : low_byte_q;
            default: low_byte_q <= low_byte_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // high byte
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         high_byte_q <= REG_RESET;
      else if (wr_high)
         high_byte_q <= wr_data;
      else if (mode_t'(mode) == MODE_SPLIT)
      begin
         if (is_timer0 && high_inc)
            high_byte_q <= high_sum[7:0];
      end
      else if (low_inc)
      begin
         if (mode_t'(mode) == MODE_13BIT && low5_sum[5])
            high_byte_q <= high_sum[7:0];
         else if (mode_t'(mode) == MODE_16BIT && low_sum[8])
            high_byte_q <= high_sum[7:0];
      end
   end
endmodule : timer_count_unit

// >>> tb/dual_timer_counter_chk.sv
// port checker for the dual timer/counter
// assumes: bound to the top module, one clock, synchronous reset
`timescale 1ns/1ps
module dual_timer_counter_chk
   import dual_timer_counter_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic ext_irq0_input,
   input wire logic ext_irq1_input,
   input wire logic ext_irq1_ack,
   input wire logic timer0_ack,
   input wire logic ext_irq0_req,
   input wire logic ext_irq1_req,
   input wire logic timer0_overflow_flag,
   input wire logic timer1_overflow_flag
);
   ////////////////////////////////////////
   logic [7:0] mode_q;
   logic [7:0] ctl_q;
   logic wr_ctl;
   logic clr0;
   logic set0;
   logic set1;
   // causes that may move a flag
   assign wr_ctl = sfr_wr && sfr_addr == TIMER_CONTROL_FLAGS_ADDR;
   assign clr0 = timer0_ack || (wr_ctl && !sfr_wdata[T0_OVF_BIT]);
   assign set0 = ctl_q[T0_RUN_BIT] || (wr_ctl && sfr_wdata[T0_OVF_BIT]);
   assign set1 = ctl_q[T1_RUN_BIT] || (wr_ctl && sfr_wdata[T1_OVF_BIT]);
   // mirror of written bytes; only software-owned bits are relied on
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         mode_q <= REG_RESET;
         ctl_q <= REG_RESET;
      end
      else
      begin
         if (sfr_wr && sfr_addr == TIMER_MODE_SELECT_ADDR)
            mode_q <= sfr_wdata;
         if (wr_ctl)
            ctl_q <= sfr_wdata;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_low0;
      (!ext_irq0_input && !ctl_q[IRQ0_TYPE_BIT])[*4];
   endsequence
   sequence s_quiet1;
      ext_irq1_input[*6] ##0 (ext_irq1_ack && ctl_q[IRQ1_TYPE_BIT] && !wr_ctl);
   endsequence
   property p_rst_clear;
      disable iff (1'b0) sys_rst |=> !timer0_overflow_flag && !timer1_overflow_flag
         && !ext_irq0_req && !ext_irq1_req && sfr_rdata == REG_RESET;
   endproperty
   property p_unmapped;
      sfr_rd && (sfr_addr < TIMER_CONTROL_FLAGS_ADDR || sfr_addr > TIMER1_HIGH_BYTE_ADDR)
         |=> sfr_rdata == REG_RESET;
   endproperty
   property p_mode_read;
      sfr_rd && sfr_addr == TIMER_MODE_SELECT_ADDR |=> sfr_rdata == $past(mode_q);
   endproperty
   property p_tf0_fall;
      $fell(timer0_overflow_flag) |-> $past(clr0, 2);
   endproperty
   property p_tf0_rise;
      $rose(timer0_overflow_flag) |-> $past(set0, 2);
   endproperty
   property p_tf1_rise;
      $rose(timer1_overflow_flag) |-> $past(set1, 2);
   endproperty
   property p_level0;
      s_low0 |-> ext_irq0_req;
   endproperty
   property p_ack1;
      s_quiet1 |=> ##1 !ext_irq1_req;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("state not cleared by reset");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");
   a_tf0_fall: assert property (p_tf0_fall) else $error("timer 0 flag lost");
   a_tf0_rise: assert property (p_tf0_rise) else $error("timer 0 flag while stopped");
   a_tf1_rise: assert property (p_tf1_rise) else $error("timer 1 flag while stopped");
   a_level0: assert property (p_level0) else $error("low level not requested");
   a_ack1: assert property (p_ack1) else $error("edge request kept after ack");
endmodule : dual_timer_counter_chk

// >>> tb/input_pins.sv
// far-side model: counted pins and interrupt inputs
// assumes: called from the bench; levels change at falling clk
`timescale 1ns/1ps
module input_pins
(
   input wire logic clk,
   output logic [3:0] pin_q
);
   // idle high, as the inputs sit on pull-ups
   initial pin_q = 4'hF;
   task automatic drive(input int sel, input logic v);
      @(negedge clk);
      pin_q[sel] = v;
   endtask : drive
   // each level held len clocks so every edge is seen
   task automatic pulse(input int sel, input int n, input int len);
      repeat (n)
      begin
         drive(sel, 1'b0);
         repeat (len) @(negedge clk);
         pin_q[sel] = 1'b1;
         repeat (len) @(negedge clk);
      end
   endtask : pulse
endmodule : input_pins

// >>> tb/test_dual_timer_counter.sv
// self-checking bench for the dual timer/counter
// assumes: pin model input_pins and checker dual_timer_counter_chk
`timescale 1ns/1ps
module test_dual_timer_counter
   import dual_timer_counter_pkg::*;
;
   typedef struct {logic [7:0] m, lo, hi, tl, th, on, ctl, etl, eth;} ovf_t;
   typedef struct {logic [7:0] m, on, lo; int sel, n; logic [7:0] e;} pin_t;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic [3:0] acks = 4'h0;
   logic [3:0] pins;
   logic ext_irq0_req, ext_irq1_req, timer0_overflow_flag, timer1_overflow_flag;
   logic rd_pend = 1'b0;
   logic [7:0] r;
   int mismatches = 0;
   int cmp_count = 0;
   logic [7:0] exp_q[$];
   string name_q[$];
   ovf_t ovf[7] = '{
      '{8'h01, 8'h8A, 8'h8C, 8'hFF, 8'hFF, 8'h10, 8'h30, 8'h01, 8'h00},
      '{8'h00, 8'h8A, 8'h8C, 8'h1F, 8'hFF, 8'h10, 8'h30, 8'h01, 8'h00},
      '{8'h22, 8'h8A, 8'h8C, 8'hFF, 8'hF0, 8'h10, 8'h30, 8'hF1, 8'hF0},
      '{8'h03, 8'h8A, 8'h8C, 8'hFF, 8'hFF, 8'h50, 8'hF0, 8'h01, 8'h01},
      '{8'h10, 8'h8B, 8'h8D, 8'hFF, 8'hFF, 8'h40, 8'hC0, 8'h01, 8'h00},
      '{8'h30, 8'h8B, 8'h8D, 8'h05, 8'h07, 8'h40, 8'h40, 8'h05, 8'h07},
      '{8'h20, 8'h8B, 8'h8D, 8'hFF, 8'h80, 8'h40, 8'hC0, 8'h81, 8'h80}};
   pin_t pcs[4] = '{'{8'h05, 8'h10, 8'h8A, 0, 3, 8'h03}, '{8'h09, 8'h10, 8'h8A, 0, 2, 8'h02},
      '{8'h90, 8'h40, 8'h8B, 1, 4, 8'h04}, '{8'h90, 8'h00, 8'h8B, 1, 2, 8'h00}};
   always #25 clk = ~clk;
   dual_timer_counter dut (.clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
      .timer0_pin(pins[0]), .timer1_pin(pins[1]), .ext_irq0_input(pins[2]),
      .ext_irq1_input(pins[3]), .ext_irq0_ack(acks[0]), .ext_irq1_ack(acks[1]),
      .timer0_ack(acks[2]), .timer1_ack(acks[3]), .ext_irq0_req, .ext_irq1_req,
      .timer0_overflow_flag, .timer1_overflow_flag);
   input_pins far (.clk, .pin_q(pins));
   ////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test
   // each access takes two cycles, so strobes never toggle twice at once
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
      exp_q.push_back(e);
      name_q.push_back(what);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
   endtask : rd
   task automatic ack(input int k);
      @(negedge clk);
      acks[k] = 1'b1;
      @(negedge clk);
      acks[k] = 1'b0;
   endtask : ack
   // read data lands the cycle after the read is taken
   always @(posedge clk)
      rd_pend <= sfr_rd;
   always @(negedge clk)
      if (rd_pend)
         check(name_q.pop_front(), exp_q.pop_front(), sfr_rdata);
   // hang guard
   initial
   begin
      repeat (100000) @(posedge clk);
      mismatches++;
      stop_test();
   end
   ////////////////////////////////////////
   initial
   begin
      void'($urandom(32'h6963F30B));
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      for (int a = 8'h87; a <= 8'h8E; a++)
         rd(8'(a), 8'h00, "reset value");
      repeat (4)
      begin
         r = 8'($urandom());
         if (r[1:0] == 2'h2)
            r[5:4] = 2'h2;
         wr(TIMER_MODE_SELECT_ADDR, r);
         rd(TIMER_MODE_SELECT_ADDR, r, "mode");
      end
      // 120 clocks of run time hold exactly ten machine cycles
      r = 8'($urandom_range(8'hF0));
      wr(TIMER_MODE_SELECT_ADDR, 8'h01);
      wr(TIMER0_LOW_BYTE_ADDR, r);
      wr(TIMER_CONTROL_FLAGS_ADDR, 8'h10);
      repeat (118) @(negedge clk);
      wr(TIMER_CONTROL_FLAGS_ADDR, 8'h00);
      repeat (30) @(negedge clk);
      rd(TIMER0_LOW_BYTE_ADDR, r + 8'h0A, "timed count");
      // 24-clock window gives two counts across an overflow, except timer 1 in mode 3, which holds
      foreach (ovf[i])
      begin
         wr(ovf[i].lo, ovf[i].tl);
         wr(ovf[i].hi, ovf[i].th);
         wr(TIMER_MODE_SELECT_ADDR, ovf[i].m);
         wr(TIMER_CONTROL_FLAGS_ADDR, ovf[i].on);
         repeat (17) @(negedge clk);
         rd(TIMER_CONTROL_FLAGS_ADDR, ovf[i].ctl, "run flags");
         repeat (3) @(negedge clk);
         wr(TIMER_CONTROL_FLAGS_ADDR, 8'h00);
         rd(ovf[i].lo, ovf[i].etl, "low count");
         rd(ovf[i].hi, ovf[i].eth, "high count");
      end
      // pin edges counted by select or gate bit, none while stopped
      foreach (pcs[i])
      begin
         wr(TIMER_MODE_SELECT_ADDR, pcs[i].m);
         wr(pcs[i].lo, 8'h00);
         wr(TIMER_CONTROL_FLAGS_ADDR, pcs[i].on);
         far.pulse(pcs[i].sel, pcs[i].n, 24);
         repeat (60) @(negedge clk);
         wr(TIMER_CONTROL_FLAGS_ADDR, 8'h00);
         rd(pcs[i].lo, pcs[i].e, "pin count");
      end
      // edge type: flags set by a fall, cleared on acknowledge
      wr(TIMER_CONTROL_FLAGS_ADDR, 8'h05);
      far.pulse(2, 1, 24);
      far.pulse(3, 1, 24);
      rd(TIMER_CONTROL_FLAGS_ADDR, 8'h0F, "edge flags");
      check("edge req", 8'h03, {6'h00, ext_irq1_req, ext_irq0_req});
      ack(0);
      ack(1);
      repeat (3) @(negedge clk);
      rd(TIMER_CONTROL_FLAGS_ADDR, 8'h05, "acked flags");
      // level type: request follows the low input, no flag kept
      wr(TIMER_CONTROL_FLAGS_ADDR, 8'h00);
      far.drive(2, 1'b0);
      repeat (8) @(negedge clk);
      check("level req", 8'h01, {7'h00, ext_irq0_req});
      rd(TIMER_CONTROL_FLAGS_ADDR, 8'h00, "level flags");
      far.drive(2, 1'b1);
      repeat (8) @(negedge clk);
      check("level req", 8'h00, {7'h00, ext_irq0_req});
      // overflow flags cleared by acknowledge
      wr(TIMER_CONTROL_FLAGS_ADDR, 8'hA0);
      repeat (2) @(negedge clk);
      check("flag out", 8'h03, {6'h00, timer1_overflow_flag, timer0_overflow_flag});
      ack(2);
      ack(3);
      repeat (2) @(negedge clk);
      rd(TIMER_CONTROL_FLAGS_ADDR, 8'h00, "acked timers");
      repeat (4) @(negedge clk);
      stop_test();
   end
endmodule : test_dual_timer_counter
bind dual_timer_counter dual_timer_counter_chk chk (.clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd,
   .sfr_wdata, .sfr_rdata, .ext_irq0_input, .ext_irq1_input, .ext_irq1_ack, .timer0_ack,
   .ext_irq0_req, .ext_irq1_req, .timer0_overflow_flag, .timer1_overflow_flag);
